// [src/ptc_top.sv]
// Push-button up/down tap counter with scan modes and shutdown.
// Assumes raw active-low button levels from pins and a free-running sys_clk.
`timescale 1ns/1ps

// Contract
// - Four-bit position counter, up adds, down subtracts
// - Exactly one of sixteen taps selected
// - Inputs idle high, low means pressed
// - Lows shorter than debounce leave counter unchanged
// - One debounced press moves exactly one step
// - Held press steps at slow rate first
// - After one second held, step fast
// - Release stops stepping, returns idle, keeps value
// - Presses over 15 ms apart ignored until release
// - Counter saturates at both ends
// - Both held two seconds enters shutdown
// - Shutdown opens top, selects bottom, keeps position
// - Press over 15 ms leaves shutdown, restores
// - Still held 250 ms after exit, auto-step
// - Reset starts counter at zero
// - Slow step every 250 ms
// - Fast step every 50 ms
module ptc_top #(
    parameter int unsigned CLKS_PER_MS = ptc_pkg::MS_CYCLES
) (
    input  wire logic                      sys_clk,            // System clock
    input  wire logic                      resetn,             // Async reset, active low
    input  wire logic                      step_up_button_n,   // Raw up button, low pressed
    input  wire logic                      step_down_button_n, // Raw down button, low pressed
    output logic [ptc_pkg::TAPS-1:0]       tap_select,         // One-hot tap switches
    output logic                           top_array_terminal, // Top terminal switch closed
    output logic [ptc_pkg::POS_W-1:0]      wiper_position,     // Saved counter value
    output logic                           shutdown_active     // Shutdown mode flag
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Saturating one-step move
    function automatic logic [ptc_pkg::POS_W-1:0] ptc_step(
        input logic [ptc_pkg::POS_W-1:0] pos,
        input logic                      up
    );
        logic [ptc_pkg::POS_W-1:0] res;
        res = pos;
        if (up && pos != ptc_pkg::POS_TOP) begin
            res = pos + 4'h1;
        end else if (!up && pos != ptc_pkg::POS_RESET) begin
            res = pos - 4'h1;
        end
        return res;
    endfunction

    // Position to one-hot tap select
    function automatic logic [ptc_pkg::TAPS-1:0] ptc_onehot(
        input logic [ptc_pkg::POS_W-1:0] pos
    );
        logic [ptc_pkg::TAPS-1:0] res;
        res = '0;
        res[pos] = 1'b1;
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    ptc_pkg::ptc_regs_t         r;
    ptc_pkg::ptc_regs_t         n;
    logic                       up_low;
    logic                       dn_low;
    logic                       held;
    logic [ptc_pkg::TMR_W-1:0]  tmr_inc;
    logic [ptc_pkg::TMR_W-1:0]  interval;

    localparam logic [ptc_pkg::PRE_W-1:0] PRE_LAST = ptc_pkg::PRE_W'(CLKS_PER_MS - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        n = r;
        // Two-flop synchronisers, only the second stage is read
        n.sync1 = '{up: step_up_button_n, dn: step_down_button_n};
        n.sync2 = r.sync1;
        // Millisecond tick
        if (r.pre == PRE_LAST) begin
            n.pre  = '0;
            n.tick = 1'b1;
        end else begin
            n.pre  = r.pre + 20'h00001;
            n.tick = 1'b0;
        end
        up_low   = ~r.sync2.up;
        dn_low   = ~r.sync2.dn;
        held     = r.up_dir ? up_low : dn_low;
        tmr_inc  = r.tick ? r.tmr + 12'h001 : r.tmr;
        interval = (r.hold > ptc_pkg::FAST_AFTER_MS) ? ptc_pkg::FAST_STEP_MS
                                                     : ptc_pkg::SLOW_STEP_MS;
        case (r.st)
            ptc_pkg::st_idle: begin
                if (up_low || dn_low) begin
                    n.st     = ptc_pkg::st_arm;
                    n.up_dir = up_low;
                    n.tmr    = '0;
                end
            end
            ptc_pkg::st_arm: begin
                if (up_low && dn_low) begin
                    n.tmr = '0;
                    if (r.tmr < ptc_pkg::DEBOUNCE_MS) begin
                        n.st = ptc_pkg::st_both;
                    end else begin
                        n.st = ptc_pkg::st_lock;
                    end
                end else if (!held) begin
                    n.st = ptc_pkg::st_idle;
                end else if (tmr_inc >= ptc_pkg::DEBOUNCE_MS) begin
                    n.pos  = ptc_step(r.pos, r.up_dir);
                    n.st   = ptc_pkg::st_hold;
                    n.tmr  = '0;
                    n.hold = '0;
                end else begin
                    n.tmr = tmr_inc;
                end
            end
            ptc_pkg::st_hold: begin
                if (up_low && dn_low) begin
                    n.st = ptc_pkg::st_lock;
                end else if (!held) begin
                    n.st = ptc_pkg::st_idle;
                end else if (r.tick) begin
                    if (r.hold <= ptc_pkg::FAST_AFTER_MS) begin
                        n.hold = r.hold + 12'h001;
                    end
                    if (tmr_inc >= interval) begin
                        n.pos = ptc_step(r.pos, r.up_dir);
                        n.tmr = '0;
                    end else begin
                        n.tmr = tmr_inc;
                    end
                end
            end
            ptc_pkg::st_both: begin
                if (!up_low || !dn_low) begin
                    n.st = ptc_pkg::st_lock;
                end else if (tmr_inc >= ptc_pkg::SHUTDOWN_MS) begin
                    n.shut = 1'b1;
                    n.st   = ptc_pkg::st_sd_wait;
                end else begin
                    n.tmr = tmr_inc;
                end
            end
            ptc_pkg::st_lock: begin
                if (!up_low && !dn_low) begin
                    n.st = ptc_pkg::st_idle;
                end
            end
            ptc_pkg::st_sd_wait: begin
                // Both buttons must come up before shutdown can be left
                if (!up_low && !dn_low) begin
                    n.st = ptc_pkg::st_sd_idle;
                end
            end
            ptc_pkg::st_sd_idle: begin
                if (up_low || dn_low) begin
                    n.st     = ptc_pkg::st_sd_arm;
                    n.up_dir = up_low;
                    n.tmr    = '0;
                end
            end
            ptc_pkg::st_sd_arm: begin
                if (!held) begin
                    n.st = ptc_pkg::st_sd_idle;
                end else if (tmr_inc > ptc_pkg::DEBOUNCE_MS) begin
                    n.shut = 1'b0;
                    n.st   = ptc_pkg::st_sd_hold;
                    n.tmr  = '0;
                end else begin
                    n.tmr = tmr_inc;
                end
            end
            ptc_pkg::st_sd_hold: begin
                if (up_low && dn_low) begin
                    n.st = ptc_pkg::st_lock;
                end else if (!held) begin
                    n.st = ptc_pkg::st_idle;
                end else if (tmr_inc > ptc_pkg::SD_REPEAT_MS) begin
                    n.pos  = ptc_step(r.pos, r.up_dir);
                    n.st   = ptc_pkg::st_hold;
                    n.tmr  = '0;
                    n.hold = '0;
                end else begin
                    n.tmr = tmr_inc;
                end
            end
            default: begin
                n = ptc_pkg::REGS_RESET;
            end
        endcase
        // Registered decode, bottom tap and open top in shutdown
        n.tap = n.shut ? ptc_pkg::TAP_BOTTOM : ptc_onehot(n.pos);
        n.top = ~n.shut;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r <= ptc_pkg::REGS_RESET;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from flops
    assign tap_select         = r.tap;
    assign top_array_terminal = r.top;
    assign wiper_position     = r.pos;
    assign shutdown_active    = r.shut;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    onehot_tap_a: assert property ($onehot(r.tap))
        else $error("tap select not one-hot");

    tap_match_a: assert property (!r.shut |-> r.tap == ptc_onehot(r.pos))
        else $error("tap select does not follow position");

    shut_tap_a: assert property (r.shut |-> r.tap == ptc_pkg::TAP_BOTTOM && !r.top)
        else $error("shutdown output wrong");

    step_size_a: assert property ($changed(r.pos) |->
        (r.pos == $past(r.pos) + 4'h1) || (r.pos == $past(r.pos) - 4'h1))
        else $error("position moved by more than one");

    no_wrap_a: assert property ($past(r.pos) == ptc_pkg::POS_TOP
        |-> r.pos != ptc_pkg::POS_RESET)
        else $error("counter wrapped");

    step_cause_a: assert property ($changed(r.pos) |->
        $past(r.st) inside {ptc_pkg::st_arm, ptc_pkg::st_hold, ptc_pkg::st_sd_hold})
        else $error("position changed outside stepping");

    lock_hold_a: assert property (r.st == ptc_pkg::st_lock |=> $stable(r.pos))
        else $error("position changed while locked");

    release_idle_a: assert property (r.st == ptc_pkg::st_hold && !up_low && !dn_low
        |=> r.st == ptc_pkg::st_idle ##1 $stable(r.pos))
        else $error("release did not stop stepping");

    slow_gap_a: assert property (r.st == ptc_pkg::st_hold
        && r.hold <= ptc_pkg::FAST_AFTER_MS |-> r.tmr < ptc_pkg::SLOW_STEP_MS)
        else $error("slow step interval exceeded");

    fast_gap_a: assert property (r.st == ptc_pkg::st_hold
        && r.hold > ptc_pkg::FAST_AFTER_MS
        |-> r.tmr < ptc_pkg::FAST_STEP_MS || $past(r.hold) <= ptc_pkg::FAST_AFTER_MS)
        else $error("fast step interval exceeded");

    shut_entry_a: assert property ($rose(r.shut) |->
        $past(r.st) == ptc_pkg::st_both
        && $past(r.tmr) >= ptc_pkg::SHUTDOWN_MS - 12'h001)
        else $error("shutdown entered without two second hold");

    shut_keep_a: assert property (r.shut |=> $stable(r.pos))
        else $error("position lost in shutdown");

    shut_exit_a: assert property ($fell(r.shut) |->
        $past(r.st) == ptc_pkg::st_sd_arm && r.top)
        else $error("bad shutdown exit");

    sync_a: assert property (r.sync2 == $past(r.sync1))
        else $error("synchroniser stage skipped");

    hold_c: cover property (r.st == ptc_pkg::st_hold && r.hold > 12'h3e8 ##1 $changed(r.pos));
    shut_c: cover property ($rose(r.shut));
    exit_c: cover property (r.st == ptc_pkg::st_sd_hold ##1 r.st == ptc_pkg::st_hold);
    lock_c: cover property (r.st == ptc_pkg::st_lock);

endmodule

// [src/ptc_pkg.sv]
// Constants, state enum and register struct for the push-button tap counter.
// Assumes a single 100 MHz clock and a millisecond tick made by a prescaler.
package ptc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and prescaler
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned NS_PER_MS     = 1000000;
    localparam int unsigned MS_CYCLES     = NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned PRE_W         = 20;

    ////////////////////////////////////////////////////////////////////////////
    // Timing in milliseconds, counted in prescaler ticks
    localparam int unsigned TMR_W         = 12;
    localparam logic [11:0] DEBOUNCE_MS   = 12'h00f;   // 15 ms
    localparam logic [11:0] SLOW_STEP_MS  = 12'h0fa;   // 250 ms
    localparam logic [11:0] FAST_STEP_MS  = 12'h032;   // 50 ms
    localparam logic [11:0] FAST_AFTER_MS = 12'h3e8;   // 1 s
    localparam logic [11:0] SHUTDOWN_MS   = 12'h7d0;   // 2 s
    localparam logic [11:0] SD_REPEAT_MS  = 12'h0fa;   // 250 ms

    ////////////////////////////////////////////////////////////////////////////
    // Counter and decode
    localparam int unsigned POS_W      = 4;
    localparam int unsigned TAPS       = 16;
    localparam logic [3:0]  POS_RESET  = 4'h0;
    localparam logic [3:0]  POS_TOP    = 4'hf;
    localparam logic [15:0] TAP_BOTTOM = 16'h0001;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [3:0] {
        st_idle, st_arm, st_hold, st_both, st_lock,
        st_sd_wait, st_sd_idle, st_sd_arm, st_sd_hold
    } ptc_state_t;

    typedef struct packed {
        logic up;
        logic dn;
    } ptc_btn_t;

    typedef struct packed {
        ptc_btn_t         sync1;
        ptc_btn_t         sync2;
        logic [PRE_W-1:0] pre;
        logic             tick;
        ptc_state_t       st;
        logic             up_dir;
        logic [TMR_W-1:0] tmr;
        logic [TMR_W-1:0] hold;
        logic [POS_W-1:0] pos;
        logic             shut;
        logic [TAPS-1:0]  tap;
        logic             top;
    } ptc_regs_t;

    localparam ptc_regs_t REGS_RESET = '{
        sync1: '{up: 1'b1, dn: 1'b1}, sync2: '{up: 1'b1, dn: 1'b1},
        pre: '0, tick: 1'b0, st: st_idle, up_dir: 1'b0, tmr: '0, hold: '0,
        pos: POS_RESET, shut: 1'b0, tap: TAP_BOTTOM, top: 1'b1
    };

endpackage

// [verif/ptc_buttons.sv]
// Model of the two push-button switches that face the tap counter.
// Assumes the bench sets the press requests at the falling edge of sys_clk.
`timescale 1ns/1ps

module ptc_buttons (
    input  wire logic press_up,           // Up switch closed when high
    input  wire logic press_dn,           // Down switch closed when high
    output logic      step_up_button_n,   // Up pin, pull-up level when open
    output logic      step_down_button_n  // Down pin, pull-up level when open
);
    // A closed switch grounds the pin; an open one leaves the pull-up in charge
    assign step_up_button_n   = press_up ? 1'b0 : 1'b1;
    assign step_down_button_n = press_dn ? 1'b0 : 1'b1;
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the push-button tap counter.
// Assumes a shortened millisecond prescaler so that second-long holds stay cheap.
`timescale 1ns/1ps

module tb_top;
    localparam int unsigned CLKS = 10;

    logic                        sys_clk;
    logic                        resetn;
    logic                        press_up;
    logic                        press_dn;
    logic                        step_up_button_n;
    logic                        step_down_button_n;
    logic [ptc_pkg::TAPS-1:0]    tap_select;
    logic                        top_array_terminal;
    logic [ptc_pkg::POS_W-1:0]   wiper_position;
    logic                        shutdown_active;
    logic [3:0]                  p;
    int                          mismatches;
    int                          checks_done;

    ////////////////////////////////////////////////////////////////////////////
    // Design and switch model
    ptc_top #(.CLKS_PER_MS(CLKS)) ptc_top_inst (
        .sys_clk            (sys_clk),
        .resetn             (resetn),
        .step_up_button_n   (step_up_button_n),
        .step_down_button_n (step_down_button_n),
        .tap_select         (tap_select),
        .top_array_terminal (top_array_terminal),
        .wiper_position     (wiper_position),
        .shutdown_active    (shutdown_active)
    );

    ptc_buttons ptc_buttons_inst (
        .press_up           (press_up),
        .press_dn           (press_dn),
        .step_up_button_n   (step_up_button_n),
        .step_down_button_n (step_down_button_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic wait_ms(input int n);
        repeat (n * CLKS) @(negedge sys_clk);
    endtask

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Position and its one-hot tap decode together
    task automatic check_pos(input logic [3:0] exp);
        cmp("wiper_position", {12'h000, exp}, {12'h000, wiper_position});
        cmp("tap_select", 16'h0001 << exp, tap_select);
    endtask

    // Shutdown flag and top terminal switch move as a pair
    task automatic check_mode(input logic shut);
        cmp("shutdown_active", {15'h0000, shut}, {15'h0000, shutdown_active});
        cmp("top_array_terminal", {15'h0000, !shut}, {15'h0000, top_array_terminal});
    endtask

    // Press one button for a number of ms, release, then leave a gap
    task automatic tap_button(input logic up, input int ms);
        press_up = up;
        press_dn = !up;
        wait_ms(ms);
        press_up = 1'b0;
        press_dn = 1'b0;
        wait_ms(10);
    endtask

    task automatic finish_test;
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_short_and_single;
        tap_button(1'b1, 8);
        check_pos(4'h0);
        tap_button(1'b1, 30);
        check_pos(4'h1);
        tap_button(1'b0, 30);
        check_pos(4'h0);
        tap_button(1'b0, 30);
        check_pos(4'h0);
    endtask

    task automatic test_held;
        press_up = 1'b1;
        wait_ms(140);
        check_pos(4'h1);
        wait_ms(250);
        check_pos(4'h2);
        wait_ms(850);
        p = wiper_position;
        wait_ms(100);
        cmp("fast_steps", 16'h0002, {12'h000, wiper_position - p});
        wait_ms(500);
        check_pos(4'hf);
        press_up = 1'b0;
        wait_ms(300);
        check_pos(4'hf);
    endtask

    task automatic test_lockout;
        press_dn = 1'b1;
        wait_ms(30);
        check_pos(4'he);
        press_up = 1'b1;
        wait_ms(300);
        check_pos(4'he);
        press_dn = 1'b0;
        wait_ms(100);
        check_pos(4'he);
        press_up = 1'b0;
        wait_ms(10);
    endtask

    // Both pressed, one let go early: lockout, then a normal press again
    task automatic test_both_abort;
        press_up = 1'b1;
        press_dn = 1'b1;
        wait_ms(500);
        press_up = 1'b0;
        wait_ms(300);
        check_mode(1'b0);
        check_pos(4'hf);
        press_dn = 1'b0;
        wait_ms(10);
        tap_button(1'b0, 30);
        check_pos(4'he);
        wait_ms(300);
        check_pos(4'he);
    endtask

    task automatic test_shutdown;
        press_up = 1'b1;
        press_dn = 1'b1;
        wait_ms(1900);
        check_mode(1'b0);
        check_pos(4'he);
        wait_ms(200);
        check_mode(1'b1);
        cmp("tap_select", 16'h0001, tap_select);
        cmp("wiper_position", 16'h000e, {12'h000, wiper_position});
        press_up = 1'b0;
        press_dn = 1'b0;
        wait_ms(10);
        tap_button(1'b1, 8);
        check_mode(1'b1);
        press_up = 1'b1;
        wait_ms(30);
        check_mode(1'b0);
        check_pos(4'he);
        wait_ms(170);
        check_pos(4'he);
        wait_ms(120);
        check_pos(4'hf);
        press_up = 1'b0;
        wait_ms(10);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and main sequence
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Whole run is about 6330 ms of model time; allow 8000
    initial begin
        repeat (8000 * CLKS) @(posedge sys_clk);
        mismatches++;
        finish_test();
    end

    initial begin
        mismatches  = 0;
        checks_done = 0;
        resetn      = 1'b0;
        press_up    = 1'b0;
        press_dn    = 1'b0;
        p           = 4'h0;
        repeat (6) @(negedge sys_clk);
        check_pos(4'h0);
        check_mode(1'b0);
        resetn = 1'b1;
        wait_ms(5);
        check_pos(4'h0);
        test_short_and_single();
        test_held();
        test_lockout();
        test_shutdown();
        test_both_abort();
        finish_test();
    end
endmodule
